/* File: common/pau_map.svh */
// Purpose: offsets, field positions and timing counts of the process alarm unit
// Assumes: 25 MHz system clock
// Notes:   included by the package and the design
`ifndef PAU_MAP_SVH
`define PAU_MAP_SVH
`define PAU_CLK_HZ          25000000
`define PAU_TICK_S          1
`define PAU_TICK_CYCLES     (`PAU_CLK_HZ * `PAU_TICK_S)
`define PAU_NUM_ALARMS      4
`define PAU_VAL_W           16
`define PAU_TIME_W          13
`define PAU_TIME_MAX        6500
`define PAU_SEG_W           8
`define PAU_ADDR_W          8
// register offsets (byte addresses)
`define PAU_CTRL_OFF        8'h00
`define PAU_PROC_OFF        8'h04
`define PAU_SETPT_OFF       8'h08
`define PAU_STAT_OFF        8'h0c
`define PAU_CFG_OFF         8'h10
`define PAU_THR_OFF         8'h20
`define PAU_TIM_OFF         8'h30
// ctrl fields
`define PAU_CTRL_RUN_BIT    0
`define PAU_CTRL_FAULT_BIT  1
`define PAU_CTRL_SEGV_BIT   2
`define PAU_CTRL_SEG_LSB    8
// cfg fields per alarm (one word each: function, then blocking, then segment mask byte)
`define PAU_CFG_FUNC_LSB    0
`define PAU_CFG_BLOCK_BIT   4
`define PAU_CFG_LANE_W      8
// timer word: pulse_time low half, delay_time high half
`define PAU_TIM_PULSE_LSB   0
`define PAU_TIM_DELAY_LSB   16
`define PAU_CTRL_RESET      32'h0000_0000
`endif

/* File: common/pau_pkg.sv */
// Purpose: types of the process alarm unit
// Assumes: map header supplies the value, time and segment-mask widths
// Notes:   functions coded in a 4-bit field
`include "pau_map.svh"
package pau_pkg;
    typedef enum logic [3:0] {
        PAU_FN_OFF,
        PAU_FN_SENSOR_ERR,
        PAU_FN_PROG_EVENT,
        PAU_FN_HEATER_FAIL,
        PAU_FN_ABS_MIN,
        PAU_FN_ABS_MAX,
        PAU_FN_BAND_DEV,
        PAU_FN_MIN_DEV,
        PAU_FN_MAX_DEV
    } pau_func_t;

    typedef struct packed {
        logic                          block_en;
        pau_func_t                     func;
        logic [`PAU_SEG_W-1:0]         seg_mask;
        logic signed [`PAU_VAL_W-1:0]  threshold;
        logic [`PAU_TIME_W-1:0]        pulse_time;
        logic [`PAU_TIME_W-1:0]        delay_time;
    } pau_alarm_cfg_t;

    typedef struct packed {
        logic                          run;
        logic                          sensor_fault;
        logic                          seg_valid;
        logic [2:0]                    segment;
        logic signed [`PAU_VAL_W-1:0]  process_value;
        logic signed [`PAU_VAL_W-1:0]  control_setpoint;
    } pau_proc_t;

    typedef enum logic [1:0] {
        PAU_TM_IDLE,
        PAU_TM_ON,
        PAU_TM_OFF,
        PAU_TM_DONE
    } pau_tstate_t;
endpackage : pau_pkg

/* File: design/pau_top.sv */
// Purpose: four independent process alarms with timers and initial blocking
// Assumes: APB slave, synchronous active-high reset, 25 MHz clock
// Notes:   process inputs are written by software into registers
// Overview of operation
// - four alarm channels, each with own function, threshold and timers
// - inoperative function never asserts the alarm
// - sensor-error function asserts on sensor fault input
// - program-event function asserts while running a selected segment
// - absolute minimum asserts when process value below threshold
// - absolute maximum asserts when process value above threshold
// - band deviation, positive threshold: asserts outside setpoint plus/minus threshold
// - band deviation, negative threshold: asserts inside that band
// - minimum deviation asserts below setpoint minus threshold
// - maximum deviation asserts above setpoint plus threshold
// - maximum, band and maximum-deviation also assert on sensor fault
// - both timers zero follow condition; delay only asserts after delay
// - pulse only gives one pulse of pulse time
// - both nonzero alternate on pulse time, off delay time
// - lamps show the recognized condition, not the timed output
// - blocking hides a condition present after run stops; the reset arming clears at once, as every function resets off
// - blocked alarm activates only after clear then new occurrence
// - blocking never applies to sensor-error function
// - stopped run forces all alarm outputs off
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pau_map.svh"
module pau_top (
    input  wire logic                        mclk_i,
    input  wire logic                        rst_i,
    input  wire logic                        psel_i,
    input  wire logic                        penable_i,
    input  wire logic                        pwrite_i,
    input  wire logic [`PAU_ADDR_W-1:0]      paddr_i,
    input  wire logic [31:0]                 pwdata_i,
    output logic      [31:0]                 prdata_o,
    output logic                             pready_o,
    output logic                             pslverr_o,
    output logic      [`PAU_NUM_ALARMS-1:0]  alarm_out_o,
    output logic      [`PAU_NUM_ALARMS-1:0]  alarm_lamp_o
);
    import pau_pkg::*;
    localparam int N = `PAU_NUM_ALARMS;
    localparam int TW = `PAU_TIME_W;
    localparam logic [24:0] TICK_LAST = 25'(`PAU_TICK_CYCLES - 1);

    pau_proc_t                 proc_q;
    pau_alarm_cfg_t            cfg_q [N];
    logic [24:0]               div_q;
    logic                      tick_q;
    logic                      run_prev_q;
    logic [N-1:0]              cond;
    logic [N-1:0]              recog_q;
    logic [N-1:0]              blocked_q;
    logic [N-1:0]              out_d;
    pau_tstate_t               ts_q [N];
    logic [TW-1:0]             cnt_q [N];

    wire access = psel_i & penable_i;
    wire wr_en  = access & pwrite_i;

    // which alarm slot an offset addresses, -1 when none
    function automatic int slot(input logic [`PAU_ADDR_W-1:0] a, input logic [`PAU_ADDR_W-1:0] base);
        int r;
        r = -1;
        if (a >= base && a < base + 8'(4 * N) && a[1:0] == 2'b00) begin
            r = int'((a - base) >> 2);
        end
        return r;
    endfunction : slot

    function automatic logic mapped(input logic [`PAU_ADDR_W-1:0] a);
        return a == `PAU_CTRL_OFF || a == `PAU_PROC_OFF || a == `PAU_SETPT_OFF || a == `PAU_STAT_OFF
            || slot(a, `PAU_CFG_OFF) >= 0 || slot(a, `PAU_THR_OFF) >= 0 || slot(a, `PAU_TIM_OFF) >= 0;
    endfunction : mapped

    // apb: zero wait states, slave error on unmapped
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i & ~pready_o & ~penable_i ? 1'b1 : 1'b0;
            pslverr_o <= psel_i & ~penable_i & ~mapped(paddr_i);
        end
    end

    wire wr_take = wr_en & pready_o & ~pslverr_o;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            proc_q <= '0;
        end else if (wr_take) begin
            if (paddr_i == `PAU_CTRL_OFF) begin
                proc_q.run          <= pwdata_i[`PAU_CTRL_RUN_BIT];
                proc_q.sensor_fault <= pwdata_i[`PAU_CTRL_FAULT_BIT];
                proc_q.seg_valid    <= pwdata_i[`PAU_CTRL_SEGV_BIT];
                proc_q.segment      <= pwdata_i[`PAU_CTRL_SEG_LSB +: 3];
            end
            if (paddr_i == `PAU_PROC_OFF) begin
                proc_q.process_value <= pwdata_i[`PAU_VAL_W-1:0];
            end
            if (paddr_i == `PAU_SETPT_OFF) begin
                proc_q.control_setpoint <= pwdata_i[`PAU_VAL_W-1:0];
            end
        end
    end

    // per-alarm configuration, each channel independent
    generate
        for (genvar g = 0; g < N; g++) begin : g_cfg
            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    cfg_q[g] <= '0;
                end else if (wr_take) begin
                    if (slot(paddr_i, `PAU_CFG_OFF) == g) begin
                        cfg_q[g].func     <= pau_func_t'(pwdata_i[`PAU_CFG_FUNC_LSB +: 4]);
                        cfg_q[g].block_en <= pwdata_i[`PAU_CFG_BLOCK_BIT];
                        cfg_q[g].seg_mask <= pwdata_i[`PAU_CFG_LANE_W +: `PAU_SEG_W];
                    end
                    if (slot(paddr_i, `PAU_THR_OFF) == g) begin
                        cfg_q[g].threshold <= pwdata_i[`PAU_VAL_W-1:0];
                    end
                    if (slot(paddr_i, `PAU_TIM_OFF) == g) begin
                        cfg_q[g].pulse_time <= pwdata_i[`PAU_TIM_PULSE_LSB +: TW];
                        cfg_q[g].delay_time <= pwdata_i[`PAU_TIM_DELAY_LSB +: TW];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            prdata_o <= '0;
        end else if (psel_i & ~penable_i & ~pwrite_i) begin
            prdata_o <= '0;
            if (paddr_i == `PAU_CTRL_OFF) begin
                prdata_o <= {21'h0, proc_q.segment, 5'h0, proc_q.seg_valid, proc_q.sensor_fault, proc_q.run};
            end
            if (paddr_i == `PAU_PROC_OFF) begin
                prdata_o <= {16'h0, proc_q.process_value};
            end
            if (paddr_i == `PAU_SETPT_OFF) begin
                prdata_o <= {16'h0, proc_q.control_setpoint};
            end
            if (paddr_i == `PAU_STAT_OFF) begin
                prdata_o <= {16'h0, 4'h0, blocked_q, alarm_lamp_o, alarm_out_o};
            end
            for (int i = 0; i < N; i++) begin
                if (slot(paddr_i, `PAU_CFG_OFF) == i) begin
                    prdata_o <= {16'h0, cfg_q[i].seg_mask, 3'h0, cfg_q[i].block_en, cfg_q[i].func};
                end
                if (slot(paddr_i, `PAU_THR_OFF) == i) begin
                    prdata_o <= {16'h0, cfg_q[i].threshold};
                end
                if (slot(paddr_i, `PAU_TIM_OFF) == i) begin
                    prdata_o <= {3'h0, cfg_q[i].delay_time, 3'h0, cfg_q[i].pulse_time};
                end
            end
        end
    end

    // one second tick
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= div_q == TICK_LAST;
            div_q  <= div_q == TICK_LAST ? '0 : div_q + 25'd1;
        end
    end

    // comparisons widened by one bit so setpoint plus threshold cannot wrap
    always_comb begin
        logic signed [`PAU_VAL_W:0] pv;
        logic signed [`PAU_VAL_W:0] hi;
        logic signed [`PAU_VAL_W:0] lo;
        logic signed [`PAU_VAL_W:0] th;
        pv   = '0;
        hi   = '0;
        lo   = '0;
        th   = '0;
        cond = '0;
        for (int i = 0; i < N; i++) begin
            // signed source, so a negative threshold keeps its sign
            th = cfg_q[i].threshold;
            pv = proc_q.process_value;
            hi = proc_q.control_setpoint + th;
            lo = proc_q.control_setpoint - th;
            case (cfg_q[i].func)
                PAU_FN_OFF:        cond[i] = 1'b0;
                PAU_FN_SENSOR_ERR: cond[i] = proc_q.sensor_fault;
                PAU_FN_PROG_EVENT: cond[i] = proc_q.seg_valid & cfg_q[i].seg_mask[proc_q.segment];
                PAU_FN_ABS_MIN:    cond[i] = pv < th;
                PAU_FN_ABS_MAX:    cond[i] = pv > th | proc_q.sensor_fault;
                PAU_FN_BAND_DEV:   cond[i] = (th >= 0 ? (pv < lo || pv > hi)
                                                      : (pv > hi && pv < lo))
                                             | proc_q.sensor_fault;
                PAU_FN_MIN_DEV:    cond[i] = pv < lo;
                PAU_FN_MAX_DEV:    cond[i] = pv > hi | proc_q.sensor_fault;
                default:           cond[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= proc_q.run;
        end
    end

    // blocking armed at reset and when run falls
    generate
        for (genvar g = 0; g < N; g++) begin : g_alarm
            wire sens  = cfg_q[g].func == PAU_FN_SENSOR_ERR;
            wire arm   = run_prev_q & ~proc_q.run;
            wire rec   = cond[g] & ~(blocked_q[g] & cfg_q[g].block_en & ~sens);
            wire rise  = rec & ~recog_q[g];
            wire [TW-1:0] t1 = cfg_q[g].pulse_time;
            wire [TW-1:0] t2 = cfg_q[g].delay_time;

            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    blocked_q[g] <= 1'b1;
                end else if (arm) begin
                    blocked_q[g] <= 1'b1;
                end else if (~cond[g]) begin
                    blocked_q[g] <= 1'b0;
                end
            end

            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    recog_q[g] <= 1'b0;
                    ts_q[g]    <= PAU_TM_IDLE;
                    cnt_q[g]   <= '0;
                end else begin
                    recog_q[g] <= rec;
                    if (~rec) begin
                        ts_q[g]  <= PAU_TM_IDLE;
                        cnt_q[g] <= '0;
                    end else if (rise) begin
                        cnt_q[g] <= '0;
                        ts_q[g]  <= (t1 == '0 && t2 != '0) ? PAU_TM_OFF : PAU_TM_ON;
                    end else if (tick_q) begin
                        case (ts_q[g])
                            PAU_TM_ON: begin
                                if (t1 != '0 && cnt_q[g] + 1'b1 >= t1) begin
                                    cnt_q[g] <= '0;
                                    ts_q[g]  <= t2 == '0 ? PAU_TM_DONE : PAU_TM_OFF;
                                end else if (t1 != '0) begin
                                    cnt_q[g] <= cnt_q[g] + 1'b1;
                                end
                            end
                            PAU_TM_OFF: begin
                                if (cnt_q[g] + 1'b1 >= t2) begin
                                    cnt_q[g] <= '0;
                                    // delay only holds on; intermittent turns back on
                                    ts_q[g]  <= t1 == '0 ? PAU_TM_DONE : PAU_TM_ON;
                                end else begin
                                    cnt_q[g] <= cnt_q[g] + 1'b1;
                                end
                            end
                            default: cnt_q[g] <= cnt_q[g];
                        endcase
                    end
                end
            end

            // done means on for delay mode, off for pulse mode
            always_comb begin
                case (ts_q[g])
                    PAU_TM_ON:   out_d[g] = 1'b1;
                    PAU_TM_DONE: out_d[g] = t1 == '0;
                    default:     out_d[g] = 1'b0;
                endcase
            end
        end
    endgenerate

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            alarm_out_o  <= '0;
            alarm_lamp_o <= '0;
        end else begin
            alarm_out_o  <= out_d & recog_q & {N{proc_q.run}};
            alarm_lamp_o <= recog_q;
        end
    end
endmodule : pau_top
`default_nettype wire

/* File: tb/pau_relay_model.sv */
// Purpose: relay bank driven by the alarm outputs
// Assumes: coils pull in one clock after drive
// Notes:   contacts open in reset
`timescale 1ns/1ps
`default_nettype none
module pau_relay_model (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] coil_i,
    output logic      [3:0] contact_o
);
    // one cycle pull-in, so a single-cycle glitch shows up as a mismatch
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            contact_o <= 4'h0;
        end else begin
            contact_o <= coil_i;
        end
    end
endmodule : pau_relay_model
`default_nettype wire

/* File: tb/pau_top_props.sv */
// Purpose: port checker of the alarm unit
// Assumes: zero-wait bus slave
// Notes:   run state mirrored from bus writes
`timescale 1ns/1ps
`default_nettype none
module pau_top_props (
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [3:0]  alarm_out_o,
    input wire logic [3:0]  alarm_lamp_o
);
    logic run_q;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            run_q <= 1'b0;
        end else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h00) begin
            run_q <= pwdata_i[0];
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    property p_rdy_acc; psel_i && penable_i |-> pready_o; endproperty
    property p_rdy_only; pready_o |-> psel_i && penable_i; endproperty
    property p_rdy_one; pready_o |=> !pready_o; endproperty
    property p_err_rdy; pslverr_o |-> pready_o; endproperty
    property p_err_map; psel_i && penable_i && paddr_i >= 8'h40 |-> pslverr_o; endproperty
    property p_err_rd0; pslverr_o && !pwrite_i |-> prdata_o == 32'h0; endproperty
    property p_out_lamp; (alarm_out_o & ~alarm_lamp_o) == 4'h0; endproperty
    property p_run_off; !run_q [*3] |-> alarm_out_o == 4'h0; endproperty
    a_rdy_acc: assert property (p_rdy_acc) else $error("no ready in access");
    a_rdy_only: assert property (p_rdy_only) else $error("ready outside access");
    a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
    a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
    a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
    a_err_rd0: assert property (p_err_rd0) else $error("refused read data not zero");
    a_out_lamp: assert property (p_out_lamp) else $error("output without lamp");
    a_run_off: assert property (p_run_off) else $error("output while stopped");
    c_lamp: cover property ($rose(alarm_lamp_o[0]));
    c_out: cover property (alarm_out_o != 4'h0);
    c_err: cover property (pslverr_o);
endmodule : pau_top_props
bind pau_top pau_top_props u_props (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .alarm_out_o(alarm_out_o), .alarm_lamp_o(alarm_lamp_o));
`default_nettype wire

/* File: tb/process_alarm_unit_tb.sv */
// Purpose: self-checking bench of the alarm unit
// Assumes: zero-wait bus, one second is too long to expire here
// Notes:   timed outputs only seen in their first second
`timescale 1ns/1ps
`default_nettype none
module process_alarm_unit_tb;
    import pau_pkg::*;
    logic               mclk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               psel_i = 1'b0;
    logic               penable_i = 1'b0;
    logic               pwrite_i = 1'b0;
    logic [7:0]         paddr_i = 8'h00;
    logic [31:0]        pwdata_i = 32'h0;
    logic [31:0]        prdata_o;
    logic               pready_o;
    logic               pslverr_o;
    logic [3:0]         alarm_out_o;
    logic [3:0]         alarm_lamp_o;
    logic [3:0]         contact;
    int                 n_errors = 0;
    int                 total_checks = 0;
    int                 seed = 39506;
    int                 cyc = 0;
    int                 c;
    logic signed [15:0] pv;
    logic signed [15:0] sp;
    logic signed [15:0] thr [4];
    logic [3:0]         fn [4];
    logic [7:0]         msk [4];
    logic [31:0]        ctl;
    logic [31:0]        rd;
    logic               er;
    pau_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .alarm_out_o(alarm_out_o), .alarm_lamp_o(alarm_lamp_o));
    pau_relay_model u_relay (.mclk_i(mclk_i), .rst_i(rst_i), .coil_i(alarm_out_o), .contact_o(contact));
    initial begin
        forever #20 mclk_i = ~mclk_i;
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    // hang guard, far above the few thousand cycles the sequence needs
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        if (n == 16) n_errors++;
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    function automatic logic cond(input int k);
        logic signed [16:0] lo;
        logic signed [16:0] hi;
        lo = sp - thr[k];
        hi = sp + thr[k];
        case (fn[k])
            4'd1: return ctl[1];
            4'd2: return ctl[2] && msk[k][ctl[10:8]];
            4'd4: return pv < thr[k];
            4'd5: return pv > thr[k] || ctl[1];
            4'd6: return (thr[k] > 0 ? (pv < lo || pv > hi) : (pv > hi && pv < lo)) || ctl[1];
            4'd7: return pv < lo;
            4'd8: return pv > hi || ctl[1];
            default: return 1'b0;
        endcase
    endfunction : cond
    function automatic logic [3:0] expl();
        for (int k = 0; k < 4; k++) expl[k] = cond(k);
    endfunction : expl
    task automatic setch(input int k, input logic [31:0] tim, input logic blk);
        // timers first: the timer mode latches when the cfg write raises the condition
        apb(1'b1, 8'(48 + 4 * k), tim);
        apb(1'b1, 8'(32 + 4 * k), 32'(thr[k]));
        apb(1'b1, 8'(16 + 4 * k), {16'h0, msk[k], 3'h0, blk, fn[k]});
    endtask : setch
    task automatic proc();
        apb(1'b1, 8'h04, 32'(pv));
        apb(1'b1, 8'h08, 32'(sp));
        apb(1'b1, 8'h00, ctl);
    endtask : proc
    task automatic see(input logic [3:0] l, input logic [3:0] o);
        repeat (4) @(posedge mclk_i);
        chk(32'(alarm_lamp_o), 32'(l));
        chk(32'(alarm_out_o), 32'(o));
        chk(32'(contact), 32'(o));
        apb(1'b0, 8'h0c, 32'h0);
        chk(32'(rd[7:0]), 32'({l, o}));
    endtask : see
    initial begin
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        // every function visits every channel; edge values every third pass
        for (int i = 0; i < 72; i++) begin
            c = i % 4;
            fn[c] = 4'(i % 9);
            thr[c] = 16'(($random(seed) % 300) | 1);
            msk[c] = 8'($random(seed));
            sp = 16'($random(seed) % 400);
            pv = (i % 6 == 0) ? sp + thr[c] : (i % 6 == 3) ? thr[c] : 16'($random(seed) % 800);
            ctl = 32'($random(seed)) & 32'h0000_0707;
            setch(c, 32'h0, 1'b0);
            proc();
            see(expl(), ctl[0] ? expl() : 4'h0);
        end
        apb(1'b1, 8'h40, 32'hffff_ffff);
        chk(32'(er), 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h0c, 32'hffff_ffff);
        see(expl(), ctl[0] ? expl() : 4'h0);
        fn = '{4'd5, 4'd1, 4'd0, 4'd0};
        thr = '{16'sd100, 16'sd100, 16'sd100, 16'sd100};
        for (int k = 0; k < 4; k++) setch(k, 32'h0, k < 2);
        pv = 16'sd200;
        sp = 16'sd0;
        ctl = 32'h3;
        proc();
        apb(1'b1, 8'h00, 32'h2);
        apb(1'b1, 8'h00, 32'h3);
        see(4'b0010, 4'b0010);
        pv = 16'sd0;
        ctl = 32'h1;
        proc();
        see(4'h0, 4'h0);
        apb(1'b1, 8'h04, 32'd200);
        see(4'b0001, 4'b0001);
        fn = '{4'd5, 4'd5, 4'd5, 4'd5};
        setch(1, 32'h0002_0002, 1'b0);
        setch(2, 32'h0002_0000, 1'b0);
        setch(3, 32'h0000_0002, 1'b0);
        see(4'hf, 4'b1011);
        repeat (200) @(posedge mclk_i);
        chk(32'(alarm_out_o), 32'hb);
        apb(1'b1, 8'h04, 32'h0);
        see(4'h0, 4'h0);
        end_of_test();
    end
endmodule : process_alarm_unit_tb
`default_nettype wire
